/* src/gpb_defines.vh */
// Constants for the general-purpose I/O port bank: register map, field
// positions, reset values and the per-package line availability masks.
// Assumes inclusion by bare name from the design files.
`ifndef GPB_DEFINES_VH
`define GPB_DEFINES_VH

`define GPB_ADDR_W        5
`define GPB_DATA_W        8
`define GPB_NUM_PORTS     9
`define GPB_NUM_LINES     72
`define GPB_NUM_GROUPS    18

// Port data registers at base + port index, direction at base + index
`define GPB_DATA_BASE     5'h00
`define GPB_DIR_BASE      5'h10
`define GPB_PULLUP_A      5'h1c
`define GPB_PULLUP_B      5'h1d
`define GPB_PULLUP_C      5'h1e
`define GPB_PORT_CTRL     5'h1f

// Port index 1 is the port steered by the latch-readback bit
`define GPB_RB_PORT       1
`define GPB_RB_SEL_BIT    0
`define GPB_PULLUP_C_W    2

`define GPB_RST_DIR       8'h00
`define GPB_RST_LATCH     8'h00
`define GPB_RST_PULLUP    8'h00
`define GPB_RST_CTRL      8'h00

// Line availability, port index 8 in the top byte (71 lines)
`define GPB_AVAIL_LARGE   72'hff_ef_ff_ff_ff_ff_ff_ff_ff
// Smaller package (55 lines)
`define GPB_AVAIL_SMALL   72'hff_0f_ff_ff_ff_0f_ff_e0_0f

`endif

/* src/gpb_port.v */
// One 8-line port: direction register, output latch, pin drive and
// the data-register read path. Assumes the bank decodes the bus.
`timescale 1ns/1ps
`default_nettype none
`include "gpb_defines.vh"

module gpb_port
(
  input  wire       clk,
  input  wire       srst,
  input  wire [7:0] avail,
  input  wire       dir_we,
  input  wire       data_we,
  input  wire [7:0] wdata,
  input  wire [7:0] pin_in,
  input  wire [7:0] periph_oe,
  input  wire [7:0] periph_out,
  input  wire       force_latch,
  output wire [7:0] rd_data,
  output wire [7:0] rd_dir,
  output reg  [7:0] pin_out,
  output reg  [7:0] pin_oe
);

  reg  [7:0] port_direction_reg;
  reg  [7:0] out_latch;
  reg  [7:0] next_pin_out;
  reg  [7:0] next_pin_oe;
  integer    i;

  assign rd_dir = port_direction_reg;

  // Input lines show the pin, output lines the latch
  assign rd_data = avail & (force_latch ? out_latch                                  // [R12]
    : ((port_direction_reg & out_latch) | (~port_direction_reg & pin_in)));           // [R6] [R7]

  always @(posedge clk)
  begin
    if (srst)
    begin
      port_direction_reg <= `GPB_RST_DIR;                                             // [R13]
      out_latch          <= `GPB_RST_LATCH;
    end
    else
    begin
      if (dir_we)
        port_direction_reg <= wdata & avail;                                          // [R2] [R3]
      // Latch is written in either direction so an output turns on clean
      if (data_we)
        out_latch <= wdata;                                                           // [R6] [R7]
    end
  end

  always @*
  begin
    next_pin_out = 8'h00;
    next_pin_oe  = 8'h00;
    for (i = 0; i < 8; i = i + 1)
    begin
      if (avail[i] && periph_oe[i])
      begin
        // Peripheral output wins over the direction bit
        next_pin_oe[i]  = 1'b1;                                                       // [R5]
        next_pin_out[i] = periph_out[i];
      end
      else if (avail[i] && port_direction_reg[i])
      begin
        next_pin_oe[i]  = 1'b1;                                                       // [R3]
        next_pin_out[i] = out_latch[i];                                               // [R8]
      end
    end
  end

  always @(posedge clk)
  begin
    if (srst)
    begin
      pin_out <= 8'h00;
      pin_oe  <= 8'h00;
    end
    else
    begin
      pin_out <= next_pin_out;
      pin_oe  <= next_pin_oe;
    end
  end

endmodule
`default_nettype wire

/* src/gpb_bank.v */
// General-purpose I/O port bank: nine 8-line ports, grouped pull-ups,
// latch-readback control and the register slave.
// Assumes pins and peripheral requests are synchronous to clk.
//
// Operation
// R1: 71 lines in the large package, 55 in the small one, each configurable.
// R2: Every line is set input or output by its own direction bit.
// R3: Direction bits map one-to-one onto port pins; 0 means input.
// R4: Software keeps direction 0 on pins used as peripheral inputs.
// R5: A peripheral output drives its pin regardless of the direction bit.
// R6: Input lines read the live pin; writes only load the latch.
// R7: Output lines read the latch; writes load the latch.
// R8: Output lines drive their latch value onto the pin.
// R9: One pull-up bit per four adjacent lines, over three registers.
// R10: Pull-up active only when group enable is 1 and direction is 0.
// R11: Pull-up ignores pin function; only enable and direction count.
// R12: Readback bit set makes port 1 reads return its latch.
// R13: Reset clears direction, pull-ups and readback: inputs without pull-up.
`timescale 1ns/1ps
`default_nettype none
`include "gpb_defines.vh"

module gpb_bank
#(
  parameter SMALL_PKG = 0
)
(
  input  wire        clk,
  input  wire        srst,
  input  wire [4:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  input  wire [71:0] pin_in,
  input  wire [71:0] periph_oe,
  input  wire [71:0] periph_out,
  output wire [71:0] pin_out,
  output wire [71:0] pin_oe,
  output reg  [71:0] pin_pullup
);

  // Lines missing from the package never drive and read as zero
  localparam [71:0] AVAIL = (SMALL_PKG != 0) ? `GPB_AVAIL_SMALL
                                             : `GPB_AVAIL_LARGE;  // [R1]

  reg  [7:0]  pullup_ctrl_reg_a;
  reg  [7:0]  pullup_ctrl_reg_b;
  reg  [1:0]  pullup_ctrl_reg_c;
  reg         latch_readback_sel;
  reg  [7:0]  next_rdata;
  reg  [71:0] next_pullup;
  wire [71:0] dir_all;
  wire [71:0] rd_all;
  wire [17:0] group_en;
  integer     k;

  // Decode used by both the write and read paths
  function hit_port;
    input [4:0] addr;
    input [4:0] base;
    begin
      hit_port = (addr[4] == base[4]) && (addr[3:0] < `GPB_NUM_PORTS);
    end
  endfunction

  function [3:0] port_index;
    input [4:0] addr;
    begin
      port_index = addr[3:0];
    end
  endfunction

  genvar p;
  generate
    for (p = 0; p < `GPB_NUM_PORTS; p = p + 1)
    begin : g_port
      wire dir_we;
      wire data_we;
      wire force_latch;

      assign dir_we  = reg_wr && hit_port(reg_addr, `GPB_DIR_BASE)
                       && (port_index(reg_addr) == p);            // [R2]
      assign data_we = reg_wr && hit_port(reg_addr, `GPB_DATA_BASE)
                       && (port_index(reg_addr) == p);
      // Only port 1 obeys the readback bit
      assign force_latch = (p == `GPB_RB_PORT) && latch_readback_sel; // [R12]

      gpb_port u_port
      (
        .clk         (clk),
        .srst        (srst),
        .avail       (AVAIL[p*8 +: 8]),
        .dir_we      (dir_we),
        .data_we     (data_we),
        .wdata       (reg_wdata),
        .pin_in      (pin_in[p*8 +: 8]),
        .periph_oe   (periph_oe[p*8 +: 8]),
        .periph_out  (periph_out[p*8 +: 8]),
        .force_latch (force_latch),
        .rd_data     (rd_all[p*8 +: 8]),
        .rd_dir      (dir_all[p*8 +: 8]),
        .pin_out     (pin_out[p*8 +: 8]),
        .pin_oe      (pin_oe[p*8 +: 8])
      );
    end
  endgenerate

  assign group_en = {pullup_ctrl_reg_c, pullup_ctrl_reg_b, pullup_ctrl_reg_a}; // [R9]

  // Control registers
  always @(posedge clk)
  begin
    if (srst)
    begin
      pullup_ctrl_reg_a  <= `GPB_RST_PULLUP;                     // [R13]
      pullup_ctrl_reg_b  <= `GPB_RST_PULLUP;
      pullup_ctrl_reg_c  <= 2'b00;
      latch_readback_sel <= 1'b0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `GPB_PULLUP_A:
          pullup_ctrl_reg_a <= reg_wdata;                        // [R9]
        `GPB_PULLUP_B:
          pullup_ctrl_reg_b <= reg_wdata;
        `GPB_PULLUP_C:
          pullup_ctrl_reg_c <= reg_wdata[`GPB_PULLUP_C_W-1:0];
        `GPB_PORT_CTRL:
          latch_readback_sel <= reg_wdata[`GPB_RB_SEL_BIT];      // [R12]
        default:
          latch_readback_sel <= latch_readback_sel;
      endcase
    end
  end

  // Pull-up depends only on group enable and direction, never on
  // whether a peripheral has taken the pin over
  always @*
  begin
    next_pullup = 72'h0;
    for (k = 0; k < `GPB_NUM_LINES; k = k + 1)
      next_pullup[k] = AVAIL[k] && group_en[k/4] && !dir_all[k]; // [R10] [R11]
  end

  always @(posedge clk)
  begin
    if (srst)
      pin_pullup <= 72'h0;                                       // [R13]
    else
      pin_pullup <= next_pullup;
  end

  // Read mux; unmapped and reserved bits answer zero
  always @*
  begin
    next_rdata = 8'h00;
    if (hit_port(reg_addr, `GPB_DATA_BASE))
      next_rdata = rd_all[port_index(reg_addr)*8 +: 8];          // [R6] [R7] [R12]
    else if (hit_port(reg_addr, `GPB_DIR_BASE))
      next_rdata = dir_all[port_index(reg_addr)*8 +: 8];
    else
    begin
      case (reg_addr)
        `GPB_PULLUP_A:  next_rdata = pullup_ctrl_reg_a;
        `GPB_PULLUP_B:  next_rdata = pullup_ctrl_reg_b;
        `GPB_PULLUP_C:  next_rdata = {6'h00, pullup_ctrl_reg_c};
        `GPB_PORT_CTRL: next_rdata = {7'h00, latch_readback_sel};
        default:        next_rdata = 8'h00;
      endcase
    end
  end

  // Data valid only in the cycle after the read strobe
  always @(posedge clk)
  begin
    if (srst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= 8'h00;
  end

endmodule
`default_nettype wire

/* tb/gpb_pins.sv */
// Pin-side partner: outside drivers, pull-ups and floating lines.
// Assumes the bank's pin outputs reach the pads directly.
`timescale 1ns/1ps
`default_nettype none
module gpb_pins (
  input wire logic        clk,
  input wire logic [71:0] pin_out,
  input wire logic [71:0] pin_oe,
  input wire logic [71:0] pin_pullup,
  input wire logic [71:0] ext_val,
  input wire logic [71:0] ext_en,
  output logic     [71:0] pin_in
);
  logic flip = 1'b0;
  // Floating lines toggle so a stale level never reads as right
  always_ff @(posedge clk) flip <= ~flip;
  always_comb pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & (pin_pullup | {72{flip}}));
endmodule
`default_nettype wire

/* tb/gpb_bank_sva.sv */
// Checker for the port bank's pin drive, pull-up and read relations.
// Assumes the bound bank passes down its package choice.
`timescale 1ns/1ps
`default_nettype none
`include "gpb_defines.vh"
module gpb_bank_sva #(
  parameter SMALL_PKG = 0
) (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [4:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic [71:0] pin_in,
  input wire logic [71:0] periph_oe,
  input wire logic [71:0] periph_out,
  input wire logic [71:0] pin_out,
  input wire logic [71:0] pin_oe,
  input wire logic [71:0] pin_pullup
);
  localparam logic [71:0] M = (SMALL_PKG != 0) ? `GPB_AVAIL_SMALL : `GPB_AVAIL_LARGE;
  logic [71:0] oe_d;
  logic [71:0] out_d;
  always_ff @(posedge clk) oe_d <= periph_oe;
  always_ff @(posedge clk) out_d <= periph_out;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  AST_OE_PERIPH: assert property (1 |=> (pin_oe & oe_d) == (oe_d & M))
    else $error("peripheral enable not driven");
  AST_OUT_PERIPH: assert property (1 |=> ((pin_out ^ out_d) & oe_d & M) == 72'h0)
    else $error("peripheral value not driven");
  AST_PU_DIR: assert property ((pin_pullup & pin_oe & ~oe_d) == 72'h0)
    else $error("pull-up on output line");
  AST_UNAVAIL: assert property (((pin_oe | pin_pullup) & ~M) == 72'h0)
    else $error("missing line active");
  AST_RST: assert property (disable iff (1'b0) srst |=> !(|{pin_oe, pin_pullup, reg_rdata}))
    else $error("state not cleared");
  AST_DIR_WR: assert property (reg_wr && reg_addr == `GPB_DIR_BASE |-> ##2
    pin_oe[7:0] == (($past(reg_wdata, 2) | oe_d[7:0]) & M[7:0]))
    else $error("direction not applied");
  AST_RD_PORT: assert property (reg_rd && reg_addr == 5'h00 && !$past(reg_wr)
    && oe_d[7:0] == 8'h00 |=>
    reg_rdata == $past((pin_out & pin_oe | pin_in & ~pin_oe) & M & 72'hff))
    else $error("port read path wrong");
  COV_RB: cover property (reg_rd && reg_addr == 5'h01);
  COV_PU: cover property (|(periph_oe & pin_pullup));
  COV_DIR: cover property (reg_wr && reg_addr == `GPB_DIR_BASE);
endmodule
bind gpb_bank gpb_bank_sva #(.SMALL_PKG(SMALL_PKG)) u_gpb_bank_sva (.clk(clk), .srst(srst),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .pin_in(pin_in), .periph_oe(periph_oe), .periph_out(periph_out), .pin_out(pin_out),
  .pin_oe(pin_oe), .pin_pullup(pin_pullup));
`default_nettype wire

/* tb/gpb_bank_tb.sv */
// Self-checking bench for the port bank over its register port.
// Assumes the map in the defines header; a small-package bank shares the bus.
`timescale 1ns/1ps
`default_nettype none
`include "gpb_defines.vh"
module gpb_bank_tb;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [4:0]  reg_addr = 5'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic [71:0] pin_in, pin_out, pin_oe, pin_pullup;
  logic [71:0] periph_oe = 72'h0;
  logic [71:0] periph_out = 72'h0;
  logic [71:0] ext_val = 72'h0;
  logic [71:0] ext_en = 72'h0;
  int          err_count = 0;
  int          n_checks = 0;
  gpb_bank #(.SMALL_PKG(0)) u_gpb_bank (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_in(pin_in), .periph_oe(periph_oe), .periph_out(periph_out), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup(pin_pullup));
  gpb_pins u_gpb_pins (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
  logic [7:0]  s_rdata;
  logic [71:0] s_pin_out, s_pin_oe, s_pin_pullup;
  // Same bus and pins, smaller package mask
  gpb_bank #(.SMALL_PKG(1)) u_gpb_bank_small (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(s_rdata),
    .pin_in(pin_in), .periph_oe(periph_oe), .periph_out(periph_out), .pin_out(s_pin_out),
    .pin_oe(s_pin_oe), .pin_pullup(s_pin_pullup));
  initial forever #2 clk = ~clk;
  task automatic cmp72(input logic [71:0] got, input logic [71:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    cmp72({64'h0, got}, {64'h0, exp});
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 cmp8(reg_rdata, e);
  endtask
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic print_verdict;
    if (err_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (2000) @(posedge clk);
    err_count++;
    print_verdict();
  end
  initial
  begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    for (int a = 16; a < 32; a++) rd(a[4:0], 8'h00);
    cmp72(pin_oe | pin_pullup, 72'h0);
    // Outside drives only lines left as inputs
    ext_en <= 72'hffa5;
    ext_val <= 72'h99c3;
    wr(`GPB_DIR_BASE, 8'h5a);
    wr(`GPB_DATA_BASE, 8'h0f);
    settle();
    cmp72(pin_oe, 72'h5a);
    cmp72(pin_out & pin_oe, 72'h0a);
    rd(`GPB_DATA_BASE, 8'h8b);
    wr(5'h01, 8'h3c);
    rd(5'h01, 8'h99);
    wr(`GPB_PORT_CTRL, 8'h01);
    rd(5'h01, 8'h3c);
    rd(`GPB_DATA_BASE, 8'h8b);
    wr(`GPB_PULLUP_A, 8'h81);
    wr(`GPB_PULLUP_C, 8'hff);
    periph_oe <= 72'h1;
    periph_out <= 72'h1;
    settle();
    cmp72(pin_pullup, 72'hff_0000_0000_f000_0005);
    cmp72(pin_oe & pin_out, 72'h0b);
    rd(`GPB_PULLUP_C, 8'h03);
    wr(`GPB_DIR_BASE, 8'hff);
    settle();
    cmp72(pin_pullup, 72'hff_0000_0000_f000_0000);
    cmp72(s_pin_oe, 72'h0f);
    cmp72(s_pin_out, 72'h0f);
    cmp72(s_pin_pullup, 72'hff_0000_0000_0000_0000);
    wr(5'h17, 8'hff);
    rd(5'h17, 8'hef);
    cmp8(s_rdata, 8'h0f);
    wr(5'h0a, 8'h55);
    rd(5'h0a, 8'h00);
    @(posedge clk);
    periph_oe <= 72'h0;
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    rd(`GPB_DIR_BASE, 8'h00);
    cmp72(pin_oe | pin_pullup, 72'h0);
    cmp72(s_pin_oe | s_pin_pullup, 72'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
